// File: src/sync_serial_pkg.sv
`default_nettype none

package sync_serial_pkg;

    // ------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------
    localparam logic [1:0] ADDR_BUFFER = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_CONTROL = 2'h2;
    localparam logic [1:0] ADDR_IRQ = 2'h3;
    localparam int STAT_SMP_BIT = 7;
    localparam int STAT_CKE_BIT = 6;
    localparam int STAT_BF_BIT = 0;
    localparam int CTL_WRITE_COLLISION_FLAG_BIT = 7;
    localparam int CTL_EN_BIT = 5;
    localparam int CTL_CKP_BIT = 4;
    localparam int IRQ_FLAG_BIT = 0;
    localparam logic [7:0] BUFFER_RESET = 8'h00;
    localparam logic [3:0] MODE_RESET = 4'h0;

    // ------------------------------------------------------------
    // Modes and timing
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MODE_MASTER_DIV4 = 4'h0,
        MODE_MASTER_DIV16 = 4'h1,
        MODE_MASTER_DIV64 = 4'h2,
        MODE_MASTER_DIV128 = 4'h3,
        MODE_SLAVE_SS = 4'h4,
        MODE_SLAVE_NOSS = 4'h5
    } mode_type;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_RUN = 1'b1
    } master_state_type;

    localparam logic [6:0] HALF_DIV4 = 7'h02;
    localparam logic [6:0] HALF_DIV16 = 7'h08;
    localparam logic [6:0] HALF_DIV64 = 7'h20;
    localparam logic [6:0] HALF_DIV128 = 7'h40;
    localparam logic [4:0] LAST_TICK = 5'h10;
    localparam logic [4:0] LAST_OUT_TICK = 5'h0F;
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } reg_req_type;

endpackage : sync_serial_pkg

`default_nettype wire

// File: src/sync_serial_spi_core.sv
`default_nettype none

// ----------------------------------------------------------------
// Slave shifter on the external serial clock
// ----------------------------------------------------------------
module slave_link
    import sync_serial_pkg::*;
(
    // Link clock and reset request from core domain
    input wire logic link_sck,
    input wire logic rst,
    // Quasi-static configuration and transmit byte
    input wire logic cfg_slave,
    input wire logic cfg_use_ss,
    input wire logic [7:0] tx_byte,
    // Serial pins
    input wire logic ss_n,
    input wire logic sdi,
    output logic sdo,
    // Results toward the core domain
    output logic [7:0] rx_byte,
    output logic done_tgl,
    output logic active
);

    typedef struct packed {
        logic [1:0] rst_meta;
        logic [1:0] cfg_meta0;
        logic [1:0] cfg_meta1;
        logic [2:0] cnt;
        logic [7:0] sr;
        logic [7:0] rx;
        logic done;
        logic act;
    } link_state_type;

    link_state_type lk_q, lk_d;
    logic run, frame_clr;

    // Sync the static controls first; edges only come during frames
    assign run = lk_q.cfg_meta0[1] && (!lk_q.cfg_meta1[1] || !ss_n);
    // Select high ends a cut frame at once; no link edges come then
    assign frame_clr = ss_n && lk_q.cfg_meta1[1];

    always_comb begin
        lk_d = lk_q;
        lk_d.rst_meta = {lk_q.rst_meta[0], rst};
        lk_d.cfg_meta0 = {lk_q.cfg_meta0[0], cfg_slave};
        lk_d.cfg_meta1 = {lk_q.cfg_meta1[0], cfg_use_ss};
        if (lk_q.rst_meta[1] || !run) begin
            lk_d.cnt = 3'h0;
            lk_d.act = 1'b0;
            // Toggle cleared only by reset, never by a disable
            if (lk_q.rst_meta[1]) begin
                lk_d.done = 1'b0;
            end
        end else if (lk_q.cnt == 3'h0) begin
            lk_d.sr = {tx_byte[6:0], sdi};
            lk_d.cnt = 3'h1;
            lk_d.act = 1'b1;
        end else if (lk_q.cnt == LAST_BIT) begin
            lk_d.rx = {lk_q.sr[6:0], sdi};
            lk_d.done = !lk_q.done;
            lk_d.cnt = 3'h0;
            lk_d.act = 1'b0;
        end else begin
            lk_d.sr = {lk_q.sr[6:0], sdi};
            lk_d.cnt = lk_q.cnt + 3'h1;
        end
    end

    // Limitation: reset needs link edges while select is not clearing
    always_ff @(posedge link_sck or posedge frame_clr) begin
        if (frame_clr) begin
            lk_q.cnt <= 3'h0;
            lk_q.act <= 1'b0;
        end else begin
            lk_q <= lk_d;
        end
    end

    // Before the first edge the byte's top bit comes from the buffer
    assign sdo = (lk_q.cnt == 3'h0) ? tx_byte[7] : lk_q.sr[7];
    assign rx_byte = lk_q.rx;
    assign done_tgl = lk_q.done;
    assign active = lk_q.act;

endmodule : slave_link

// ----------------------------------------------------------------
// Core: register port, master engine, slave result capture
// ----------------------------------------------------------------
module sync_serial_spi_core
    import sync_serial_pkg::*;
(
    // System clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire reg_req_type req,
    output logic [7:0] rdata,
    // Serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    // Serial data and select pins
    input wire logic sdi,
    input wire logic ss_n,
    output logic sdo,
    output logic sdo_oe_n
);

    typedef struct packed {
        logic [7:0] buffer;
        logic [7:0] rx_sr;
        logic [7:0] tx_sr;
        logic bf;
        logic irq;
        logic write_collision_flag;
        logic sample_phase_sel;
        logic cke;
        logic en;
        logic ckp;
        mode_type mode;
        master_state_type st;
        logic [4:0] tick;
        logic [6:0] half_cnt;
        logic sck;
        logic sdo;
        logic sck_oe_n;
        logic sdo_oe_n;
        logic [7:0] rdata;
        logic [1:0] done_sync;
        logic done_seen;
        logic [1:0] act_sync;
    } core_state_type;

    core_state_type st_q, st_d;
    logic is_master, busy, done_evt, start, tick_evt, do_out, do_samp;
    logic sample_odd, link_sdo, link_done, link_act;
    logic [7:0] link_rx, rx_next;
    logic [6:0] half;

    // ------------------------------------------------------------
    // Slave shifter instance
    // ------------------------------------------------------------
    slave_link u_link (
        .link_sck(sck_in),
        .rst(rst),
        .cfg_slave(st_q.en && !is_master),
        .cfg_use_ss(st_q.mode == MODE_SLAVE_SS),
        .tx_byte(st_q.buffer),
        .ss_n(ss_n),
        .sdi(sdi),
        .sdo(link_sdo),
        .rx_byte(link_rx),
        .done_tgl(link_done),
        .active(link_act)
    );

    // Mode decode and master rate
    assign is_master = (st_q.mode <= MODE_MASTER_DIV128);
    always_comb begin
        case (st_q.mode)
            MODE_MASTER_DIV16: half = HALF_DIV16;
            MODE_MASTER_DIV64: half = HALF_DIV64;
            MODE_MASTER_DIV128: half = HALF_DIV128;
            default: half = HALF_DIV4;
        endcase
    end

    // Completion: slave toggle edge after two flops, or the master's last tick; rx word is stable
    assign done_evt = (st_q.done_sync[1] != st_q.done_seen) ||
                      (tick_evt && st_q.tick == LAST_TICK);
    assign busy = (st_q.st == ST_RUN) || st_q.act_sync[1];
    assign start = req.wr && req.addr == ADDR_BUFFER && !busy && is_master && st_q.en;
    assign tick_evt = (st_q.st == ST_RUN) && (st_q.half_cnt == 7'h00);

    // Output and sample moments within the sixteen half periods
    assign sample_odd = !(st_q.cke ^ st_q.sample_phase_sel);
    assign do_out = st_q.cke ? (st_q.tick[0] && st_q.tick < LAST_OUT_TICK)
                             : (!st_q.tick[0] && st_q.tick < LAST_TICK);
    assign do_samp = (st_q.tick[0] == sample_odd) && (st_q.tick[0] ||
                     ((st_q.tick != 5'h00 || st_q.cke) && (st_q.tick != LAST_TICK || !st_q.cke)));
    assign rx_next = (tick_evt && do_samp) ? {st_q.rx_sr[6:0], sdi} : st_q.rx_sr;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.done_sync = {st_q.done_sync[0], link_done};
        st_d.done_seen = st_q.done_sync[1];
        st_d.act_sync = {st_q.act_sync[0], link_act};
        st_d.rdata = 8'h00;
        // Register writes; only the buffer address reaches the shifter
        if (req.wr) begin
            if (req.addr == ADDR_BUFFER) begin
                if (busy) begin
                    st_d.write_collision_flag = 1'b1;
                end else begin
                    st_d.buffer = req.wdata;
                end
            end else if (req.addr == ADDR_STATUS) begin
                st_d.sample_phase_sel = req.wdata[STAT_SMP_BIT];
                st_d.cke = req.wdata[STAT_CKE_BIT];
            end else if (req.addr == ADDR_CONTROL) begin
                st_d.write_collision_flag = st_q.write_collision_flag && req.wdata[CTL_WRITE_COLLISION_FLAG_BIT];
                st_d.en = req.wdata[CTL_EN_BIT];
                st_d.ckp = req.wdata[CTL_CKP_BIT];
                st_d.mode = mode_type'(req.wdata[3:0]);
            end else begin
                st_d.irq = st_q.irq && req.wdata[IRQ_FLAG_BIT];
            end
        end
        // Register reads; shift registers have no address
        if (req.rd) begin
            if (req.addr == ADDR_BUFFER) begin
                st_d.rdata = st_q.buffer;
                st_d.bf = 1'b0;
            end else if (req.addr == ADDR_STATUS) begin
                st_d.rdata = {st_q.sample_phase_sel, st_q.cke, 5'h00, st_q.bf};
            end else if (req.addr == ADDR_CONTROL) begin
                st_d.rdata = {st_q.write_collision_flag, 1'b0, st_q.en, st_q.ckp, st_q.mode};
            end else begin
                st_d.rdata = {7'h00, st_q.irq};
            end
        end
        // Master engine, one case per state
        case (st_q.st)
            ST_IDLE: begin
                st_d.sck = st_q.ckp;
                if (start) begin
                    st_d.st = ST_RUN;
                    st_d.tick = 5'h00;
                    st_d.half_cnt = half - 7'h01;
                    st_d.tx_sr = req.wdata;
                    if (st_q.cke) begin
                        st_d.sdo = req.wdata[7];
                        st_d.tx_sr = {req.wdata[6:0], 1'b0};
                    end
                end
            end
            ST_RUN: begin
                if (tick_evt) begin
                    st_d.half_cnt = half - 7'h01;
                    st_d.rx_sr = rx_next;
                    if (st_q.tick < LAST_TICK) begin
                        st_d.sck = !st_q.sck;
                        st_d.tick = st_q.tick + 5'h01;
                    end else begin
                        st_d.st = ST_IDLE;
                    end
                    if (do_out) begin
                        st_d.sdo = st_q.tx_sr[7];
                        st_d.tx_sr = {st_q.tx_sr[6:0], 1'b0};
                    end
                end else begin
                    st_d.half_cnt = st_q.half_cnt - 7'h01;
                end
            end
            default: st_d.st = ST_IDLE;
        endcase
        // Completion wins over a same-cycle read or clear
        if (done_evt) begin
            st_d.buffer = (st_q.st == ST_RUN) ? rx_next : link_rx;
            st_d.bf = 1'b1;
            st_d.irq = 1'b1;
        end
        st_d.sck_oe_n = !(st_d.en && st_d.mode <= MODE_MASTER_DIV128);
        st_d.sdo_oe_n = !st_d.en;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q <= '0;
            st_q.buffer <= BUFFER_RESET;
            st_q.mode <= mode_type'(MODE_RESET);
            st_q.sck_oe_n <= 1'b1;
            st_q.sdo_oe_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Pins; slave data comes from the link shifter
    assign rdata = st_q.rdata;
    assign sck_out = st_q.sck;
    assign sck_oe_n = st_q.sck_oe_n;
    assign sdo = is_master ? st_q.sdo : link_sdo;
    assign sdo_oe_n = st_q.sdo_oe_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_done_flags: assert property (@(posedge sys_clk) disable iff (rst)
        done_evt |=> st_q.bf && st_q.irq)
        else $error("completion did not set full and irq");
    chk_done_buffer: assert property (@(posedge sys_clk) disable iff (rst)
        done_evt && st_q.st == ST_IDLE |=> st_q.buffer == $past(link_rx))
        else $error("slave byte not loaded into buffer");
    chk_write_collision_flag_drop: assert property (@(posedge sys_clk) disable iff (rst)
        req.wr && req.addr == ADDR_BUFFER && busy && !done_evt |=>
        st_q.write_collision_flag && $stable(st_q.buffer))
        else $error("busy write not refused");
    chk_bf_read: assert property (@(posedge sys_clk) disable iff (rst)
        req.rd && req.addr == ADDR_BUFFER && !done_evt |=> !st_q.bf)
        else $error("buffer read left full flag");
    chk_msb_start: assert property (@(posedge sys_clk) disable iff (rst)
        start && st_q.cke |=> st_q.sdo == $past(req.wdata[7]))
        else $error("first bit is not msb");
    chk_irq_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        st_q.irq && !(req.wr && req.addr == ADDR_IRQ) |=> st_q.irq)
        else $error("irq flag dropped by itself");
    chk_sck_idle: assert property (@(posedge sys_clk) disable iff (rst)
        st_q.st == ST_IDLE && $past(st_q.st == ST_IDLE) |-> st_q.sck == $past(st_q.ckp))
        else $error("idle clock level wrong");
    chk_master_len: assert property (@(posedge sys_clk) disable iff (rst)
        start && st_q.mode == MODE_MASTER_DIV4 |=> (st_q.st == ST_RUN) [*8] ##27 st_q.bf)
        else $error("fast master byte length wrong");
    chk_hold_tx: assert property (@(posedge sys_clk) disable iff (rst)
        !done_evt && !(req.wr && req.addr == ADDR_BUFFER) |=> $stable(st_q.buffer))
        else $error("buffer changed without cause");

endmodule : sync_serial_spi_core

`default_nettype wire

// File: testbench/spi_far_end.sv
`default_nettype none

// ------------------------------------------------------------
// Far end: slave on the core's clock, master on the link clock
// ------------------------------------------------------------
module spi_far_end (
    // Pins from the core, and the test's clock phase setting
    input wire logic sck_out,
    input wire logic sck_oe_n,
    input wire logic sdo,
    input wire logic cke,
    // Pins toward the core
    output var logic sck_in,
    output var logic sdi,
    output var logic ss_n,
    // Byte seen on the wire
    output var logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] txs;
    int n;

    // Link clock stands low outside frames
    initial begin
        sck_in = 1'b0;
        sdi = 1'b0;
        ss_n = 1'b1;
        rx = 8'h00;
        txs = 8'h00;
        n = 99;
    end

    // Arm the slave side; early output puts the msb out at once
    task automatic load(input logic [7:0] b);
        n = 0;
        txs = b;
        if (cke) begin
            sdi = txs[7];
            txs = txs << 1;
        end
    endtask

    // Slave side: one edge presents, the other samples
    always @(sck_out) begin
        if (!sck_oe_n && n < 16) begin
            n = n + 1;
            if (n[0] ^ cke) begin
                sdi <= txs[7];
                txs = txs << 1;
            end else begin
                rx <= {rx[6:0], sdo};
            end
            // Early-output frames end on edge 16; late ones sample after it when sample_phase_sel is set
            if (n == 16 && cke) sdi <= ~sdi;
        end
    end

    // Link edges with select high, to clear the link side under reset
    task automatic idle_clocks(input int k);
        ss_n = 1'b1;
        for (int i = 0; i < k; i++) begin
            #16;
            sck_in = 1'b1;
            #32;
            sck_in = 1'b0;
            #16;
        end
    endtask

    // Master side: 64 ns clock, select raised only on an aborted frame
    task automatic send(input logic [7:0] b, input int nbits);
        ss_n = 1'b0;
        rx = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            sdi = b[7 - i];
            #16;
            rx = {rx[6:0], sdo};
            sck_in = 1'b1;
            #32;
            sck_in = 1'b0;
            #16;
        end
        sdi = ~sdi;
        if (nbits < 8) ss_n = 1'b1;
    endtask
endmodule // spi_far_end

`default_nettype wire

// File: testbench/sync_serial_spi_core_tb_top.sv
`default_nettype none

module sync_serial_spi_core_tb_top import sync_serial_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    reg_req_type req = '0;
    logic [7:0] rdata, far_rx, tx, st, ctl;
    logic sck_in, sck_out, sck_oe_n, sdi, ss_n, sdo, sdo_oe_n;
    logic cke = 1'b0;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    // 250 MHz core clock
    always #2 sys_clk = ~sys_clk;

    sync_serial_spi_core DUT (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdi(sdi), .ss_n(ss_n),
        .sdo(sdo), .sdo_oe_n(sdo_oe_n));

    spi_far_end far (.sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo(sdo), .cke(cke),
        .sck_in(sck_in), .sdi(sdi), .ss_n(ss_n), .rx(far_rx));

    // ------------------------------------------------------------
    // Register port tasks and comparison
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        req <= '0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rdchk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        req <= '0;
        #1;
        check(rdata, exp);
    endtask

    // Bounded poll of the full flag, then the whole status byte
    task automatic wait_full(input logic [7:0] exp);
        for (int i = 0; i < 1000 && rdata[STAT_BF_BIT] !== 1'b1; i++) begin
            @(posedge sys_clk);
            req <= '{wr: 1'b0, rd: 1'b1, addr: ADDR_STATUS, wdata: 8'h00};
            @(posedge sys_clk);
            req <= '0;
            #1;
        end
        check(rdata, exp);
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard, well above the slowest rate's transfers
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(ADDR_BUFFER, BUFFER_RESET);
        rdchk(ADDR_STATUS, 8'h00);
        rdchk(ADDR_CONTROL, {4'h0, MODE_RESET});
        rdchk(ADDR_IRQ, 8'h00);
        // Second reset, with link edges so the link side clears too
        @(posedge sys_clk);
        rst <= 1'b1;
        far.idle_clocks(4);
        @(posedge sys_clk);
        rst <= 1'b0;
        rdchk(ADDR_STATUS, 8'h00);
        // Every master rate, both polarities, all phase pairs
        for (int i = 0; i < 8; i++) begin
            st = {i[0], i[2] ^ i[1], 6'h00};
            ctl = {2'b00, 1'b1, i[2], 2'b00, i[1:0]};
            cke = st[STAT_CKE_BIT];
            tx = 8'h5A ^ 8'(i * 37);
            wr(ADDR_STATUS, st);
            wr(ADDR_CONTROL, ctl);
            repeat (2) @(posedge sys_clk);
            check({7'h00, sck_out}, {7'h00, ctl[CTL_CKP_BIT]});
            check({6'h00, sck_oe_n, sdo_oe_n}, 8'h00);
            far.load(~tx);
            wr(ADDR_BUFFER, tx);
            if (i == 0) begin
                wr(ADDR_BUFFER, 8'h0F);
                rdchk(ADDR_BUFFER, tx);
                rdchk(ADDR_CONTROL, ctl | 8'h80);
                wr(ADDR_CONTROL, ctl);
                rdchk(ADDR_CONTROL, ctl);
            end
            wait_full(st | 8'h01);
            check(far_rx, tx);
            rdchk(ADDR_BUFFER, ~tx);
            rdchk(ADDR_STATUS, st);
            rdchk(ADDR_IRQ, 8'h01);
            wr(ADDR_IRQ, 8'h00);
            rdchk(ADDR_IRQ, 8'h00);
        end
        // Slave with select: aborted frame, then two bytes back to back
        cke = 1'b0;
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_CONTROL, 8'h24);
        wr(ADDR_BUFFER, 8'hC3);
        repeat (2) @(posedge sys_clk);
        check({7'h00, sck_oe_n}, 8'h01);
        far.send(8'hFF, 3);
        #100;
        far.send(8'h96, 8);
        check(far_rx, 8'hC3);
        far.send(8'h69, 8);
        check(far_rx, 8'h96);
        wait_full(8'h01);
        rdchk(ADDR_BUFFER, 8'h69);
        rdchk(ADDR_STATUS, 8'h00);
        rdchk(ADDR_IRQ, 8'h01);
        results();
    end
endmodule // sync_serial_spi_core_tb_top

`default_nettype wire
